// *** core/rcd_top.sv ***
// reset sequencing, strap capture, debug halt and pod indicators
// assumes a single AHB-Lite master; pins arrive asynchronous to hclk
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module rcd_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // pins from the board and emulator
    input wire logic data_bus_bit_zero_strap,
    input wire logic strap_driven,
    input wire logic reset_pin_n,
    input wire logic break_pin,
    // core bus status, same clock
    input wire logic mem_cycle_pending,
    input wire logic mem_cycle_ack,
    // configuration and control out
    output logic boot_port_port_width_jumper,
    output logic vector_fetch,
    output logic cpu_run,
    output logic freeze_out,
    output logic wdog_reset,
    // clocks and ticks
    output logic cpu_clock_output,
    output logic baud_tick,
    output logic pit_tick,
    // show cycles and indicators
    output rcd_pkg::rcd_show_t show_bus,
    output rcd_pkg::rcd_led_t leds
);
    import rcd_pkg::*;

    logic [3:0] pins_raw;
    logic [3:0] pins_s;
    logic strap_eff;
    logic rst_pin_s;
    logic brk_pin_s;
    logic brk_pin_d;
    logic addr_ok;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] next_rdata;
    rcd_state_t state;
    rcd_state_t next_state;
    logic [11:0] seq_cnt;
    logic in_reset;
    logic halted;
    logic [1:0] chip_select_pin_assign_0;
    logic sim_freeze;
    logic [1:0] show_cycle_enable;
    logic qsm_freeze;
    logic watchdog_enable_bit;
    logic clk_double;
    logic pit_en;
    logic [7:0] pit_period;
    logic dbg_wr;
    logic brk_req;
    logic resume_req;
    logic stop_req;
    logic svc_wr;
    logic wdog_expire;
    logic [32:0] cpu_sum;
    logic [32:0] xtal_sum;
    logic [31:0] cpu_acc;
    logic [31:0] xtal_acc;
    logic xtal_tick;
    logic [11:0] stuck_cnt;
    logic stuck;

    // pins cross into hclk before anything looks at them
    assign pins_raw = {break_pin, reset_pin_n, strap_driven,
                       data_bus_bit_zero_strap};

    rcd_sync #(.WIDTH(4), .RST_VAL(RCD_PINS_RST)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(pins_raw),
        .q(pins_s)
    );

    // pull-up: a floating strap reads high
    assign strap_eff = pins_s[1] ? pins_s[0] : 1'b1;
    assign rst_pin_s = pins_s[2];
    assign brk_pin_s = pins_s[3];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brk_pin_d <= 1'b0;
        end else begin
            brk_pin_d <= brk_pin_s;
        end
    end

    // bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // narrow transfers are not supported and are ignored
    assign addr_ok = hsel && htrans[1] && hready &&
                     hsize == RCD_HSIZE_WORD;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr <= haddr[7:0];
            end
        end
    end

    // read data is fetched at the address phase so it leaves a flop
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (haddr[7:0])
            RCD_A_CHIP_SELECT_PIN_ASSIGN_0: next_rdata[1:0] = chip_select_pin_assign_0;
            RCD_A_SYSMCR: begin
                next_rdata[RCD_F_FREEZE] = sim_freeze;
                next_rdata[RCD_F_SHOW +: 2] = show_cycle_enable;
            end
            RCD_A_QSMCR: next_rdata[RCD_F_FREEZE] = qsm_freeze;
            RCD_A_SYSTEM_PROTECTION_CONTROL: next_rdata[RCD_F_SWE] = watchdog_enable_bit;
            RCD_A_CLOCK_SYNTH_CONTROL: next_rdata[RCD_F_DOUBLE] = clk_double;
            RCD_A_PITCR: begin
                next_rdata[RCD_F_PIT_EN] = pit_en;
                next_rdata[7:0] = pit_period;
            end
            RCD_A_STATUS: begin
                next_rdata[4:0] = state;
                next_rdata[5] = stuck;
                next_rdata[6] = freeze_out;
                next_rdata[7] = strap_eff;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    assign dbg_wr = wr_pend && wr_addr == RCD_A_DBGCR;
    assign svc_wr = wr_pend && wr_addr == RCD_A_WDSVC;
    assign brk_req = (dbg_wr && hwdata[RCD_F_BRK]) ||
                     (brk_pin_s && !brk_pin_d);
    assign resume_req = dbg_wr && hwdata[RCD_F_RESUME];
    assign stop_req = dbg_wr && hwdata[RCD_F_STOP];

    // sequencer: reset hold, vector fetch, then run/debug
    always_comb begin
        next_state = state;
        case (state)
            RCD_ST_RESET: begin
                if (rst_pin_s && seq_cnt == 12'h000) begin
                    next_state = RCD_ST_FETCH;
                end
            end
            RCD_ST_FETCH: begin
                if (seq_cnt == 12'h000) begin
                    next_state = RCD_ST_RUN;
                end
            end
            RCD_ST_RUN: begin
                if (brk_req) begin
                    next_state = RCD_ST_BDM;
                end else if (stop_req) begin
                    next_state = RCD_ST_HALT;
                end
            end
            RCD_ST_BDM: begin
                if (resume_req) begin
                    next_state = RCD_ST_RUN;
                end
            end
            RCD_ST_HALT: begin
                if (brk_req) begin
                    next_state = RCD_ST_BDM;
                end else if (resume_req) begin
                    next_state = RCD_ST_RUN;
                end
            end
            default: next_state = RCD_ST_RESET;
        endcase
        // watchdog bite or pin reset override everything
        if (!rst_pin_s || wdog_expire) begin
            next_state = RCD_ST_RESET;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= RCD_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_cnt <= 12'(RCD_RESET_CYC - 1);
        end else if (next_state == RCD_ST_RESET &&
                     (state != RCD_ST_RESET || !rst_pin_s)) begin
            seq_cnt <= 12'(RCD_RESET_CYC - 1);
        end else if (next_state == RCD_ST_FETCH &&
                     state != RCD_ST_FETCH) begin
            seq_cnt <= 12'(RCD_FETCH_CYC - 1);
        end else if (seq_cnt != 12'h000) begin
            seq_cnt <= seq_cnt - 12'h001;
        end
    end

    assign in_reset = state == RCD_ST_RESET;
    assign halted = state == RCD_ST_BDM || state == RCD_ST_HALT;
    assign vector_fetch = state == RCD_ST_FETCH;
    assign cpu_run = state == RCD_ST_RUN;
    assign freeze_out = state == RCD_ST_BDM;

    // strap is tracked through the whole reset hold; the last
    // sample before fetch is what the vectors are read with
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chip_select_pin_assign_0 <= RCD_CHIP_SELECT_PIN_ASSIGN_0_RST;
        end else if (in_reset) begin
            chip_select_pin_assign_0 <= {RCD_CHIP_SELECT_PIN_ASSIGN_0_RST[1], strap_eff};
        end else if (wr_pend && wr_addr == RCD_A_CHIP_SELECT_PIN_ASSIGN_0) begin
            chip_select_pin_assign_0 <= hwdata[1:0];
        end
    end

    assign boot_port_port_width_jumper = chip_select_pin_assign_0[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sim_freeze <= 1'b0;
            show_cycle_enable <= 2'h0;
        end else if (in_reset) begin
            sim_freeze <= 1'b0;
            show_cycle_enable <= 2'h0;
        end else if (wr_pend && wr_addr == RCD_A_SYSMCR) begin
            sim_freeze <= hwdata[RCD_F_FREEZE];
            show_cycle_enable <= hwdata[RCD_F_SHOW +: 2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qsm_freeze <= 1'b0;
        end else if (in_reset) begin
            qsm_freeze <= 1'b0;
        end else if (wr_pend && wr_addr == RCD_A_QSMCR) begin
            qsm_freeze <= hwdata[RCD_F_FREEZE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_enable_bit <= 1'b1;
        end else if (in_reset) begin
            watchdog_enable_bit <= 1'b1;
        end else if (wr_pend && wr_addr == RCD_A_SYSTEM_PROTECTION_CONTROL) begin
            watchdog_enable_bit <= hwdata[RCD_F_SWE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_double <= 1'b0;
        end else if (in_reset) begin
            clk_double <= 1'b0;
        end else if (wr_pend && wr_addr == RCD_A_CLOCK_SYNTH_CONTROL) begin
            clk_double <= hwdata[RCD_F_DOUBLE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pit_en <= 1'b0;
            pit_period <= RCD_PIT_RST;
        end else if (in_reset) begin
            pit_en <= 1'b0;
            pit_period <= RCD_PIT_RST;
        end else if (wr_pend && wr_addr == RCD_A_PITCR) begin
            pit_en <= hwdata[RCD_F_PIT_EN];
            pit_period <= hwdata[7:0];
        end
    end

    // internal writes mirrored on the external bus for observers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            show_bus <= '0;
        end else begin
            show_bus.valid <= wr_pend && show_cycle_enable != 2'h0;
            show_bus.addr <= wr_addr;
            show_bus.data <= hwdata;
        end
    end

    // watchdog: any write to the service word restarts it
    rcd_timer #(.WIDTH(12)) u_wdog (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(watchdog_enable_bit && !in_reset &&
             !(halted && sim_freeze)),
        .load(in_reset || svc_wr || !watchdog_enable_bit),
        .load_value(12'(RCD_WDOG_CYC - 1)),
        .expire(wdog_expire)
    );

    assign wdog_reset = wdog_expire;

    // clock synthesis by phase accumulation; crystal reference
    // stays fixed so the periodic timer ignores the double bit
    assign cpu_sum = {1'b0, cpu_acc} +
                     {1'b0, clk_double ? RCD_CPU_INC << 1 : RCD_CPU_INC};
    assign xtal_sum = {1'b0, xtal_acc} + {1'b0, RCD_XTAL_INC};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_acc <= 32'h0000_0000;
            xtal_acc <= 32'h0000_0000;
            cpu_clock_output <= 1'b0;
            baud_tick <= 1'b0;
            xtal_tick <= 1'b0;
        end else begin
            cpu_acc <= cpu_sum[31:0];
            xtal_acc <= xtal_sum[31:0];
            cpu_clock_output <= cpu_sum[31];
            baud_tick <= cpu_sum[32] && !(halted && qsm_freeze);
            xtal_tick <= xtal_sum[32];
        end
    end

    rcd_timer #(.WIDTH(12)) u_pit (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(pit_en && xtal_tick && !(halted && sim_freeze)),
        .load(in_reset || !pit_en),
        .load_value({4'h0, pit_period}),
        .expire(pit_tick)
    );

    // a cycle nobody terminates marks nonexistent memory
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stuck_cnt <= 12'h000;
        end else if (!cpu_run || !mem_cycle_pending || mem_cycle_ack) begin
            stuck_cnt <= 12'h000;
        end else if (!stuck) begin
            stuck_cnt <= stuck_cnt + 12'h001;
        end
    end

    assign stuck = stuck_cnt == 12'(RCD_STUCK_CYC);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            leds <= '0;
        end else begin
            leds.halt <= state == RCD_ST_HALT;
            leds.reset <= in_reset;
            leds.freeze <= halted || stuck;
            leds.run <= cpu_run && mem_cycle_pending;
        end
    end
endmodule
`default_nettype wire

// *** core/rcd_pkg.sv ***
// constants, field layouts and carrier types for the reset/config block
// assumes a 100 MHz hclk and an AHB-Lite master doing word transfers
//
// Behaviour
// - undriven strap reads as 1; a strap held low clears its register bit
// - sampled data bus bit zero loads bit 0 of chip-select pin assign 0
// - reset clears both show-cycle enable bits
// - any show-cycle enable set puts internal writes onto the external bus
// - a break enters background debug, stops execution, asserts freeze
// - reset clears module freeze bits; a frozen module stops while halted
// - reset sets watchdog enable (short timeout); clearing it disables
// - after reset the cpu clock is crystal times 256
// - clock-double bit doubles cpu clock; baud scales, periodic timer not
// - indicators for halt, reset, debug freeze, and running with a cycle
// - freeze and run both lit when stuck on a nonexistent-memory access
package rcd_pkg;
    localparam int unsigned RCD_CLK_MHZ = 100;
    localparam longint unsigned RCD_CLK_HZ = 64'd100000000;
    localparam longint unsigned RCD_XTAL_HZ = 64'd32768;
    localparam longint unsigned RCD_MULT = 64'd256;
    localparam logic [31:0] RCD_CPU_INC =
        32'((RCD_XTAL_HZ * RCD_MULT << 32) / RCD_CLK_HZ);
    localparam logic [31:0] RCD_XTAL_INC =
        32'((RCD_XTAL_HZ << 32) / RCD_CLK_HZ);
    // times in ns, counts rounded up to whole cycles
    localparam int unsigned RCD_RESET_NS = 2000;
    localparam int unsigned RCD_FETCH_NS = 40;
    localparam int unsigned RCD_STUCK_NS = 1000;
    localparam int unsigned RCD_WDOG_NS = 30000;
    localparam int unsigned RCD_RESET_CYC =
        (RCD_RESET_NS * RCD_CLK_MHZ + 999) / 1000;
    localparam int unsigned RCD_FETCH_CYC =
        (RCD_FETCH_NS * RCD_CLK_MHZ + 999) / 1000;
    localparam int unsigned RCD_STUCK_CYC =
        (RCD_STUCK_NS * RCD_CLK_MHZ + 999) / 1000;
    localparam int unsigned RCD_WDOG_CYC =
        (RCD_WDOG_NS * RCD_CLK_MHZ + 999) / 1000;
    // register byte offsets
    localparam logic [7:0] RCD_A_CHIP_SELECT_PIN_ASSIGN_0 = 8'h00;
    localparam logic [7:0] RCD_A_SYSMCR = 8'h04;
    localparam logic [7:0] RCD_A_QSMCR = 8'h08;
    localparam logic [7:0] RCD_A_SYSTEM_PROTECTION_CONTROL = 8'h0c;
    localparam logic [7:0] RCD_A_CLOCK_SYNTH_CONTROL = 8'h10;
    localparam logic [7:0] RCD_A_PITCR = 8'h14;
    localparam logic [7:0] RCD_A_DBGCR = 8'h18;
    localparam logic [7:0] RCD_A_STATUS = 8'h1c;
    localparam logic [7:0] RCD_A_WDSVC = 8'h20;
    // field positions
    localparam int unsigned RCD_F_FREEZE = 15;
    localparam int unsigned RCD_F_SHOW = 8;
    localparam int unsigned RCD_F_SWE = 7;
    localparam int unsigned RCD_F_DOUBLE = 0;
    localparam int unsigned RCD_F_PIT_EN = 8;
    localparam int unsigned RCD_F_BRK = 0;
    localparam int unsigned RCD_F_RESUME = 1;
    localparam int unsigned RCD_F_STOP = 2;
    // reset values
    localparam logic [1:0] RCD_CHIP_SELECT_PIN_ASSIGN_0_RST = 2'h3;
    localparam logic [7:0] RCD_PIT_RST = 8'h00;
    localparam logic [2:0] RCD_HSIZE_WORD = 3'h2;
    localparam logic [3:0] RCD_PINS_RST = 4'h5;

    typedef enum logic [4:0] {
        RCD_ST_RESET = 5'b00001,
        RCD_ST_FETCH = 5'b00010,
        RCD_ST_RUN = 5'b00100,
        RCD_ST_BDM = 5'b01000,
        RCD_ST_HALT = 5'b10000
    } rcd_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [31:0] data;
    } rcd_show_t;

    typedef struct packed {
        logic halt;
        logic reset;
        logic freeze;
        logic run;
    } rcd_led_t;
endpackage

// *** core/rcd_sync.sv ***
// two-flop synchroniser for a group of pin levels
// assumes each bit is an independent level, not a multi-bit word
`timescale 1ns/10ps
`default_nettype none
module rcd_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// *** core/rcd_timer.sv ***
// reloading down counter shared by the watchdog and periodic timer
// assumes run is a per-cycle advance and load wins over run
`timescale 1ns/10ps
`default_nettype none
module rcd_timer #(
    parameter int WIDTH = 12
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic run,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    // result
    output logic expire
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
            expire <= 1'b0;
        end else if (load) begin
            count <= load_value;
            expire <= 1'b0;
        end else if (run && count == '0) begin
            count <= load_value;
            expire <= 1'b1;
        end else begin
            count <= run ? count - 1'b1 : count;
            expire <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** tb/rcd_props.sv ***
// port assertions for the reset/config block
// assumes it is bound onto rcd_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module rcd_props (
    // clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // pins
    input wire logic data_bus_bit_zero_strap,
    input wire logic strap_driven,
    input wire logic mem_cycle_pending,
    input wire logic mem_cycle_ack,
    // outputs watched
    input wire logic boot_port_port_width_jumper,
    input wire logic vector_fetch,
    input wire logic cpu_run,
    input wire logic freeze_out,
    input wire logic wdog_reset,
    input wire rcd_pkg::rcd_show_t show_bus,
    input wire rcd_pkg::rcd_led_t leds
);
    import rcd_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic dwr;
    logic [6:0] stk;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dwr <= 1'b0;
        end else begin
            dwr <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
        end
    end
    // saturates so a long stall cannot wrap back to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stk <= 7'h0;
        end else if (!(cpu_run && mem_cycle_pending && !mem_cycle_ack)) begin
            stk <= 7'h0;
        end else if (stk != 7'h7f) begin
            stk <= stk + 7'h1;
        end
    end
    property p_fetch;
        $rose(vector_fetch) |->
            vector_fetch[*4] ##1 (!vector_fetch && cpu_run);
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("vector fetch window wrong");
    property p_strap;
        vector_fetch |->
            boot_port_port_width_jumper == (data_bus_bit_zero_strap || !strap_driven);
    endproperty
    a_strap: assert property (p_strap)
        else $error("boot port width does not follow strap");
    property p_halt;
        freeze_out |-> !cpu_run && !vector_fetch;
    endproperty
    a_halt: assert property (p_halt)
        else $error("executing while frozen");
    property p_frz_led;
        freeze_out[*2] |-> leds.freeze;
    endproperty
    a_frz_led: assert property (p_frz_led)
        else $error("freeze indicator dark in debug");
    property p_stuck;
        stk >= 7'd104 |-> leds.freeze && leds.run;
    endproperty
    a_stuck: assert property (p_stuck)
        else $error("stuck access not indicated");
    property p_show;
        show_bus.valid |-> $past(dwr) && show_bus.data == $past(hwdata);
    endproperty
    a_show: assert property (p_show)
        else $error("show cycle without matching write");
    property p_wdog;
        wdog_reset |-> ##2 (!cpu_run && !freeze_out);
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog expiry did not reset");
    property p_run_boot;
        // run is entered from fetch, or on resume from debug or stop
        $rose(cpu_run) |-> $past(vector_fetch) || $past(freeze_out) ||
            leds.halt;
    endproperty
    a_run_boot: assert property (p_run_boot)
        else $error("run entered without vector fetch");
endmodule
bind rcd_top rcd_props rcd_props_i (.*);
`default_nettype wire

// *** tb/rcd_board.sv ***
// far-side model: board strap logic and core memory cycles
// assumes the bench picks 8-bit boot and a missing-termination fault
`timescale 1ns/10ps
`default_nettype none
module rcd_board (
    // clock
    input wire logic hclk,
    // scenario controls
    input wire logic eight_bit,
    input wire logic dead,
    input wire logic cpu_run,
    // toward the device
    output logic data_bus_bit_zero_strap,
    output logic strap_driven,
    output var logic mem_cycle_pending,
    output var logic mem_cycle_ack
);
    int wait_cyc = 1;
    // undriven strap floats up; 8-bit boot holds it low via reset logic
    assign strap_driven = eight_bit;
    assign data_bus_bit_zero_strap = !eight_bit;
    initial begin
        mem_cycle_pending = 1'b0;
        mem_cycle_ack = 1'b0;
    end
    // dead models nonexistent memory: the cycle is never terminated
    always @(posedge hclk) begin
        mem_cycle_ack <= 1'b0;
        if (!mem_cycle_pending) begin
            mem_cycle_pending <= cpu_run;
            wait_cyc <= $urandom_range(3, 1);
        end else if (!dead && wait_cyc == 1) begin
            mem_cycle_ack <= 1'b1;
            mem_cycle_pending <= 1'b0;
        end else if (!dead) begin
            wait_cyc <= wait_cyc - 1;
        end
    end
endmodule
`default_nettype wire

// *** tb/rcd_bench.sv ***
// self-checking bench for the reset/config block
// assumes rcd_top, rcd_board and the bound checker are compiled
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("BAD %0t got %h exp %h", $time, g, e); \
    end \
end
module rcd_bench;
    import rcd_pkg::*;
    logic hclk, hresetn, hsel, hwrite, reset_pin_n, break_pin, eight_bit, dead;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, data_bus_bit_zero_strap, strap_driven;
    logic mem_cycle_pending, mem_cycle_ack, boot_port_port_width_jumper, vector_fetch;
    logic cpu_run, freeze_out, wdog_reset, cpu_clock_output, baud_tick;
    logic pit_tick;
    rcd_show_t show_bus;
    rcd_led_t leds;
    int fails = 0, check_count = 0, wd_seen = 0, n, a, i;
    int unsigned mdl [int];
    rcd_top rcd_top_i (.hready(hreadyout), .*);
    rcd_board rcd_board_i (.*);
    always #5 hclk = ~hclk;
    always @(posedge hclk) if (wdog_reset === 1'b1) wd_seen++;
    function automatic int unsigned msk(input int a);
        case (a)
            0: return 32'h3;
            4: return 32'h8300;
            8: return 32'h8000;
            12: return 32'h80;
            16: return 32'h1;
            20: return 32'h1ff;
            default: return 32'h0;
        endcase
    endfunction
    task automatic xfer(input logic w, input int a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= 32'(a);
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic wr(input int a, input logic [31:0] wd);
        xfer(1'b1, a, wd);
        if (mdl.exists(a)) mdl[a] = wd & msk(a);
    endtask
    task automatic rd(input int a);
        xfer(1'b0, a, 32'h0);
        `CHK({hresp, hrdata}, {1'b0, mdl.exists(a) ? mdl[a] : 32'h0})
    endtask
    task automatic boot(input logic e8);
        eight_bit <= e8;
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (5) @(posedge hclk);
        `CHK(leds.reset, 1'b1)
        for (n = 0; n < 400 && cpu_run !== 1'b1; n++) @(posedge hclk);
        `CHK(cpu_run, 1'b1)
        mdl = '{0: {30'h1, !e8}, 4: 0, 8: 0, 12: 32'h80, 16: 0, 20: 0};
    endtask
    // rising edges of the cpu clock and baud ticks over 10 us, against crystal times 256 times m
    task automatic clk_rate(input int m);
        int c, e, b;
        logic p;
        c = 0;
        b = 0;
        p = 1'b1;
        e = int'(RCD_XTAL_HZ * RCD_MULT * m / 100000);
        repeat (1000) begin
            @(posedge hclk);
            if (cpu_clock_output === 1'b1 && p === 1'b0) c++;
            if (baud_tick === 1'b1) b++;
            p = cpu_clock_output;
        end
        `CHK(c inside {[e:e + 1]}, 1'b1)
        `CHK(b inside {[e:e + 1]}, 1'b1)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #300000;
        fails++;
        summarize();
    end
    initial begin
        hclk = 1'b0;
        {hresetn, hsel, hwrite, break_pin, eight_bit, dead} = 6'h0;
        {haddr, hwdata, htrans} = '0;
        hsize = RCD_HSIZE_WORD;
        reset_pin_n = 1'b1;
        d = $urandom(32'hd9b761b7);
        boot(1'b0);
        for (a = 0; a <= 20; a += 4) rd(a);
        rd(64);
        `CHK(boot_port_port_width_jumper, 1'b1)
        for (n = 0; n < 3100 && wdog_reset !== 1'b1; n++) @(posedge hclk);
        `CHK(n inside {[2700:3010]}, 1'b1)
        $display("test defaults and watchdog done");
        boot(1'b0);
        wd_seen = 0;
        wr(12, 32'h0);
        for (i = 0; i < 4; i++) begin
            d = $urandom;
            wr(4, {16'h0, 6'h0, i[1:0], 8'h0});
            wr(20, d);
            @(posedge hclk);
            `CHK(show_bus.valid, i != 0)
            `CHK({show_bus.addr, show_bus.data}, {RCD_A_PITCR, d})
            rd(20);
        end
        clk_rate(1);
        wr(16, 32'h1);
        clk_rate(2);
        wr(16, 32'h0);
        repeat (1200) @(posedge hclk);
        `CHK(wd_seen, 0)
        $display("test show cycles and clocks done");
        wr(4, 32'h8000);
        wr(12, 32'h80);
        break_pin <= 1'b1;
        for (n = 0; n < 10 && freeze_out !== 1'b1; n++) @(posedge hclk);
        `CHK(freeze_out, 1'b1)
        repeat (2) @(posedge hclk);
        `CHK(cpu_run, 1'b0)
        `CHK(leds.freeze, 1'b1)
        // frozen watchdog must not bite however long the halt lasts
        repeat (3100) @(posedge hclk);
        `CHK(wd_seen, 0)
        wr(12, 32'h0);
        break_pin <= 1'b0;
        wr(24, 32'h2);
        repeat (3) @(posedge hclk);
        `CHK(cpu_run, 1'b1)
        wr(24, 32'h4);
        repeat (3) @(posedge hclk);
        `CHK(leds.halt, 1'b1)
        wr(24, 32'h2);
        dead <= 1'b1;
        repeat (120) @(posedge hclk);
        `CHK({leds.freeze, leds.run}, 2'h3)
        dead <= 1'b0;
        repeat (8) @(posedge hclk);
        `CHK(leds.freeze, 1'b0)
        $display("test debug and indicators done");
        boot(1'b1);
        `CHK(boot_port_port_width_jumper, 1'b0)
        rd(0);
        $display("test narrow boot done");
        summarize();
    end
endmodule
`default_nettype wire
